// [core/srp_evt_if.sv]
// Purpose: Event bundle between the partition core and its status logic
// Assumes: Single clock domain
// Notes:   Events are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface srp_evt_if;
  logic [3:0] events;
  logic       irq;
  modport src (output events, input irq);
  modport dst (input events, output irq);
endinterface
`default_nettype wire

// [core/srp_irq.sv]
// Purpose: Sticky event status, clear and enable gating onto one level output
// Assumes: Strobes from the register port on clk_sys
// Notes:   Set wins over clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module srp_irq (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register strobes
  input  wire logic       clr_we,
  input  wire logic       en_we,
  input  wire logic [3:0] wdata,
  // Status view
  output logic      [3:0] status_reg,
  output logic      [3:0] enable_reg,
  // Events
  srp_evt_if.dst          evt
);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (status_reg & ~(clr_we ? wdata : 4'h0)) | evt.events;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_reg <= srp_pkg::RESET_IRQ_ENABLE[3:0];
    end else if (en_we) begin
      enable_reg <= wdata;
    end
  end

  assign evt.irq = |(status_reg & enable_reg);
endmodule
`default_nettype wire

// [core/srp_pkg.sv]
// Purpose: Shared constants and types for the secure resource partition block
// Assumes: 32-bit register port, one word per register
// Notes:   Offsets are byte addresses
package srp_pkg;
  localparam logic [7:0]  OFF_PARTITION_CFG  = 8'h00;
  localparam logic [7:0]  OFF_ID_REG0        = 8'h04;
  localparam logic [7:0]  OFF_ID_REG1        = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STATUS     = 8'h0c;
  localparam logic [7:0]  OFF_IRQ_CLEAR      = 8'h10;
  localparam logic [7:0]  OFF_IRQ_ENABLE     = 8'h14;
  localparam logic [7:0]  OFF_CTRL_STATUS    = 8'h18;
  localparam logic [7:0]  OFF_BANK_ACCESS    = 8'h1c;
  localparam logic [7:0]  OFF_GROUP_ACCESS   = 8'h20;
  localparam int          SG_LSB             = 8;
  localparam int          CB_LSB             = 0;
  localparam logic [7:0]  EXT_SG_RESET       = 8'h80;
  localparam logic [31:0] RESET_IRQ_ENABLE   = 32'h0000_0000;
  localparam int          EV_CB_CHANGE       = 0;
  localparam int          EV_SG_CHANGE       = 1;
  localparam int          EV_ACCESS_FAULT    = 2;
  localparam int          EV_RETRY           = 3;
  localparam int          NUM_EVENTS         = 4;
  localparam int          RETRY_CYCLES       = 1;

  typedef enum logic [1:0] {
    SRP_IDLE    = 2'b00,
    SRP_SCRUB   = 2'b01,
    SRP_RETRY   = 2'b10
  } srp_state_t;

  function automatic logic [7:0] srp_min8(input logic [7:0] a, input logic [7:0] b);
    srp_min8 = (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] srp_mask8(input int impl);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if ((impl >> i) != 0) begin
        m[i] = 1'b1;
      end
    end
    srp_mask8 = m;
  endfunction
endpackage

// [core/srp_retry.sv]
// Purpose: Sequencer that scrubs wide address mode and requests stall retries
// Assumes: Change request is a one-cycle pulse
// Notes:   Walks the affected bank range one bank per cycle
`timescale 1ns/10ps
`default_nettype none
module srp_retry #(
  parameter int NUM_CB = 16
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Change request
  input  wire logic       start,
  input  wire logic [7:0] lo_bank,
  input  wire logic [7:0] hi_bank,
  // Per-bank outputs
  output logic            scrub_valid,
  output logic      [7:0] scrub_bank,
  output logic            retry_pulse,
  output logic            busy
);
  srp_pkg::srp_state_t state_reg;
  logic [7:0]          hi_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg   <= srp_pkg::SRP_IDLE;
      scrub_bank  <= 8'h00;
      hi_reg      <= 8'h00;
      scrub_valid <= 1'b0;
      retry_pulse <= 1'b0;
    end else begin
      scrub_valid <= 1'b0;
      retry_pulse <= 1'b0;
      case (state_reg)
        srp_pkg::SRP_IDLE: begin
          if (start && lo_bank < hi_bank) begin
            scrub_valid <= 1'b1;
            scrub_bank  <= lo_bank;
            hi_reg      <= hi_bank;
            state_reg   <= srp_pkg::SRP_SCRUB;
          end
        end
        // Valid and bank move together so every strobe names its own bank
        srp_pkg::SRP_SCRUB: begin
          if (scrub_bank + 8'h01 >= hi_reg) begin
            state_reg <= srp_pkg::SRP_RETRY;
          end else begin
            scrub_valid <= 1'b1;
            scrub_bank  <= scrub_bank + 8'h01;
          end
        end
        srp_pkg::SRP_RETRY: begin
          retry_pulse <= 1'b1;
          state_reg   <= srp_pkg::SRP_IDLE;
        end
        default: state_reg <= srp_pkg::SRP_IDLE;
      endcase
    end
  end

  assign busy = (state_reg != srp_pkg::SRP_IDLE);
endmodule
`default_nettype wire

// [core/srp_top.sv]
// Purpose: Secure partition of stream groups and context banks
// Assumes: Secure and Non-secure states both built in, one clock
// Notes:   Non-secure identification views are clipped by the override fields
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Bits 15 to 8 set the stream group count seen by Non-secure readers of id register 0.
// - A Non-secure access to an unimplemented group is faulted or ignored, chosen by design.
// - Unreachable upper bits of the group field have no storage, read zero and ignore writes.
// - The group field resets to the implemented group count.
// - With extended stream matching built in the group field resets to 128; the code masks it, so it is zero unless the mask has bit 7.
// - Bits 7 to 0 set the context bank count seen by Non-secure readers of id register 1.
// - A bank given to Non-secure use also gives access to its attribute and syndrome regs.
// - The bank field resets to the implemented bank count.
// - A bank field change may leave wide address mode of reallocated banks unknown.
// - Stage 2 format banks are never given to Secure use.
// - Unreachable upper bits of the bank field have no storage, read zero and ignore writes.
// - Without Secure translation contexts the bank field may be read-only.
// - A write to a stalled bank's attribute registers may retry the stalled transaction.
// - A bank field change may retry stalled transactions in every affected bank; the code issues one retry that names the lowest reallocated bank.
// - The partition register exists only with both security states built in.
module srp_top #(
  parameter int NUM_SMRG    = 16,
  parameter int NUM_CB      = 16,
  parameter int NUM_S2CB    = 4,
  parameter bit EXT_SMATCH  = 1'b0,
  parameter bit TWO_STATES  = 1'b1,
  parameter bit SEC_CTX     = 1'b1,
  parameter bit SG_FAULT    = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic        secure,
  output logic      [31:0] rdata,
  // Identification inputs
  input  wire logic [31:0] id0_raw,
  input  wire logic [31:0] id1_raw,
  // Bank and group access checks
  input  wire logic [7:0]  acc_bank,
  input  wire logic [7:0]  acc_group,
  input  wire logic        acc_group_en,
  input  wire logic        acc_ns,
  output logic             bank_ns_ok,
  output logic             group_fault,
  // Stall handling
  input  wire logic        attr_wr,
  input  wire logic [7:0]  attr_bank,
  input  wire logic        bank_stalled,
  output logic             retry_req,
  output logic      [7:0]  retry_bank,
  output logic             scrub_valid,
  output logic      [7:0]  scrub_bank,
  // Interrupt
  output logic             irq
);
  localparam logic [7:0] SG_MASK  = srp_pkg::srp_mask8(NUM_SMRG);
  localparam logic [7:0] CB_MASK  = srp_pkg::srp_mask8(NUM_CB);
  localparam logic [7:0] SG_IMPL  = 8'(NUM_SMRG);
  localparam logic [7:0] CB_IMPL  = 8'(NUM_CB);
  localparam logic [7:0] S2_IMPL  = 8'(NUM_S2CB);
  localparam logic [7:0] SG_RST   = EXT_SMATCH ? srp_pkg::EXT_SG_RESET : SG_IMPL;

  logic [7:0]  sg_override_reg;
  logic [7:0]  cb_override_reg;
  logic [7:0]  sg_override_next;
  logic [7:0]  cb_override_next;
  logic        cfg_wr;
  logic        cb_change;
  logic        sg_change;
  logic [31:0] rdata_next;
  logic [3:0]  status_view;
  logic [3:0]  enable_view;
  logic        seq_busy;
  logic        seq_retry;
  logic        attr_retry;
  logic        acc_fault;
  logic [7:0]  seq_lo;
  logic [7:0]  seq_hi;
  logic [7:0]  seq_base_reg;

  srp_evt_if evt_bus ();

  assign cfg_wr = TWO_STATES && wr_en && secure && addr == srp_pkg::OFF_PARTITION_CFG;

  // Field masks drop the storage the implemented counts cannot reach
  always_comb begin
    sg_override_next = wdata[srp_pkg::SG_LSB +: 8] & SG_MASK;
    cb_override_next = wdata[srp_pkg::CB_LSB +: 8] & CB_MASK;
    if (cb_override_next < S2_IMPL) begin
      cb_override_next = S2_IMPL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sg_override_reg <= SG_RST & SG_MASK;
    end else if (cfg_wr) begin
      sg_override_reg <= sg_override_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cb_override_reg <= CB_IMPL;
    end else if (cfg_wr && SEC_CTX) begin
      cb_override_reg <= cb_override_next;
    end
  end

  assign cb_change = cfg_wr && SEC_CTX && cb_override_next != cb_override_reg;
  assign sg_change = cfg_wr && sg_override_next != sg_override_reg;
  assign seq_lo    = srp_pkg::srp_min8(cb_override_reg, cb_override_next);
  assign seq_hi    = (cb_override_reg < cb_override_next) ? cb_override_next : cb_override_reg;

  // Banks reallocated by a change made while no walk is busy get a scrub strobe so wide address mode is not left stale
  srp_retry #(
    .NUM_CB      (NUM_CB)
  ) u_retry (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (cb_change),
    .lo_bank     (seq_lo),
    .hi_bank     (seq_hi),
    .scrub_valid (scrub_valid),
    .scrub_bank  (scrub_bank),
    .retry_pulse (seq_retry),
    .busy        (seq_busy)
  );

  // Banks below the override belong to Non-secure use
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_ns_ok  <= 1'b0;
      group_fault <= 1'b0;
    end else begin
      bank_ns_ok  <= !acc_ns || acc_bank < cb_override_reg;
      group_fault <= acc_fault;
    end
  end

  assign acc_fault = SG_FAULT && acc_group_en && acc_ns && acc_group >= SG_IMPL
                     && acc_group < sg_override_reg;

  // Lowest reallocated bank is held, a later write must not move the retry target
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq_base_reg <= 8'h00;
    end else if (cb_change && !seq_busy) begin
      seq_base_reg <= seq_lo;
    end
  end

  assign attr_retry = attr_wr && bank_stalled;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      retry_req  <= 1'b0;
      retry_bank <= 8'h00;
    end else begin
      retry_req  <= attr_retry || seq_retry;
      retry_bank <= attr_retry ? attr_bank : seq_base_reg;
    end
  end

  assign evt_bus.events = {retry_req, acc_fault, sg_change, cb_change};
  assign irq            = evt_bus.irq;

  srp_irq u_irq (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .clr_we     (wr_en && addr == srp_pkg::OFF_IRQ_CLEAR),
    .en_we      (wr_en && addr == srp_pkg::OFF_IRQ_ENABLE),
    .wdata      (wdata[3:0]),
    .status_reg (status_view),
    .enable_reg (enable_view),
    .evt        (evt_bus.dst)
  );

  // Non-secure readers see clipped counts, Secure readers see the raw ones
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (addr)
      srp_pkg::OFF_PARTITION_CFG: begin
        if (TWO_STATES && secure) begin
          rdata_next = {16'h0000, sg_override_reg, cb_override_reg};
        end
      end
      srp_pkg::OFF_ID_REG0: begin
        rdata_next = id0_raw;
        if (!secure) begin
          rdata_next[7:0] = sg_override_reg;
        end
      end
      srp_pkg::OFF_ID_REG1: begin
        rdata_next = id1_raw;
        if (!secure) begin
          rdata_next[7:0] = cb_override_reg;
        end
      end
      srp_pkg::OFF_IRQ_STATUS:  rdata_next = {28'h0000000, status_view};
      srp_pkg::OFF_IRQ_ENABLE:  rdata_next = {28'h0000000, enable_view};
      srp_pkg::OFF_CTRL_STATUS: rdata_next = {31'h00000000, seq_busy};
      default:                  rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  chk_group_reset: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> sg_override_reg == (SG_RST & SG_MASK))
    else $error("group field reset wrong");

  chk_bank_reset: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> cb_override_reg == CB_IMPL)
    else $error("bank field reset wrong");

  chk_group_mask: assert property (
    @(posedge clk_sys) disable iff (rst)
    (sg_override_reg & ~SG_MASK) == 8'h00)
    else $error("group unused bits set");

  chk_bank_mask: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cb_override_reg & ~CB_MASK) == 8'h00)
    else $error("bank unused bits set");

  chk_stage2_floor: assert property (
    @(posedge clk_sys) disable iff (rst)
    cb_override_reg >= S2_IMPL)
    else $error("bank field below stage 2 count");

  chk_ns_id1: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd_en && !secure && addr == srp_pkg::OFF_ID_REG1
    |=> rdata[7:0] == $past(cb_override_reg))
    else $error("id1 not clipped");

  chk_ns_id0: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd_en && !secure && addr == srp_pkg::OFF_ID_REG0
    |=> rdata[7:0] == $past(sg_override_reg))
    else $error("id0 not clipped");

  chk_bank_gate: assert property (
    @(posedge clk_sys) disable iff (rst)
    acc_ns && acc_bank >= cb_override_reg |=> !bank_ns_ok)
    else $error("secure bank exposed");

  chk_group_fault: assert property (
    @(posedge clk_sys) disable iff (rst)
    group_fault |-> $past(acc_ns) && $past(acc_group) >= SG_IMPL)
    else $error("group fault on implemented group");

  chk_attr_retry: assert property (
    @(posedge clk_sys) disable iff (rst)
    attr_wr && bank_stalled |=> retry_req && retry_bank == $past(attr_bank))
    else $error("stall retry missing");

  // Bank change walk: start, first scrub on the lowest bank, then a retry
  sequence s_change;
    cb_change ##1 seq_busy;
  endsequence

  sequence s_walk_start;
    cb_change && !seq_busy;
  endsequence

  sequence s_first_scrub;
    scrub_valid && scrub_bank == $past(seq_lo);
  endsequence

  chk_walk_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_walk_start |=> s_first_scrub)
    else $error("walk did not start at lowest bank");

  chk_scrub_floor: assert property (
    @(posedge clk_sys) disable iff (rst)
    scrub_valid |-> scrub_bank >= seq_base_reg)
    else $error("scrub below reallocated range");

  chk_change_retry: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_change |-> ##[1:260] retry_req)
    else $error("change retry missing");

  chk_ns_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_en && !secure |=> $stable(cb_override_reg))
    else $error("nonsecure write took effect");

  chk_ns_group_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_en && !secure |=> $stable(sg_override_reg))
    else $error("nonsecure group write took effect");

  chk_ns_cfg_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    rd_en && !secure && addr == srp_pkg::OFF_PARTITION_CFG
    |=> rdata == 32'h0000_0000)
    else $error("nonsecure read saw partition register");

  chk_ro_bank: assert property (
    @(posedge clk_sys) disable iff (rst)
    !SEC_CTX && wr_en |=> $stable(cb_override_reg))
    else $error("read-only bank field changed");

  chk_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (rst)
    !rd_en |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// [tb/srp_top_test.sv]
// Purpose: Self-checking bench for the secure resource partition block
// Assumes: Design assertions sit in the design files; the bench drives all ports
// Notes:   A second instance covers extended matching and no secure contexts
`timescale 1ns/10ps
`default_nettype none
module srp_top_test;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic        secure;
  logic [31:0] rdata;
  logic [31:0] rdata2;
  logic [31:0] id0_raw;
  logic [31:0] id1_raw;
  logic [7:0]  acc_bank;
  logic [7:0]  acc_group;
  logic        acc_group_en;
  logic        acc_ns;
  logic        bank_ns_ok;
  logic        group_fault;
  logic        attr_wr;
  logic [7:0]  attr_bank;
  logic        bank_stalled;
  logic        retry_req;
  logic [7:0]  retry_bank;
  logic        scrub_valid;
  logic [7:0]  scrub_bank;
  logic        irq;
  logic [31:0] v;
  int          n_mismatch;
  int          n_tests;

  srp_top DUT (.clk_sys, .rst, .addr, .wdata, .wr_en, .rd_en, .secure, .rdata,
    .id0_raw, .id1_raw, .acc_bank, .acc_group, .acc_group_en, .acc_ns, .bank_ns_ok,
    .group_fault, .attr_wr, .attr_bank, .bank_stalled, .retry_req, .retry_bank,
    .scrub_valid, .scrub_bank, .irq);
  // Group mask reaches bit 7 here, so the 128 reset value stays visible
  srp_top #(.NUM_SMRG(200), .EXT_SMATCH(1'b1), .SEC_CTX(1'b0)) DUT_EXT (.clk_sys, .rst,
    .addr, .wdata, .wr_en, .rd_en, .secure, .rdata(rdata2), .id0_raw, .id1_raw,
    .acc_bank, .acc_group, .acc_group_en, .acc_ns, .bank_ns_ok(), .group_fault(),
    .attr_wr, .attr_bank, .bank_stalled, .retry_req(), .retry_bank(), .scrub_valid(),
    .scrub_bank(), .irq());

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    secure <= s;
    wr_en  <= 1'b1;
    @(posedge clk_sys);
    wr_en  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic s, output logic [31:0] d);
    @(posedge clk_sys);
    addr   <= a;
    secure <= s;
    rd_en  <= 1'b1;
    @(posedge clk_sys);
    rd_en  <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Bounded watch of one bank-change walk: scrubs lo upward, then one retry
  task automatic seq_check(input logic [7:0] lo, input int n);
    int k;
    int seen;
    bit done;
    k = 0;
    seen = 0;
    done = 1'b0;
    while (!done && k < 40) begin
      #1;
      if (scrub_valid === 1'b1) begin
        chk("scrub_bank", 32'(lo) + 32'(seen), {24'h0, scrub_bank});
        seen++;
      end
      if (retry_req === 1'b1) begin
        chk("retry_bank", {24'h0, lo}, {24'h0, retry_bank});
        done = 1'b1;
      end
      k++;
      @(posedge clk_sys);
    end
    chk("scrub_count", 32'(n), 32'(seen));
    chk_bit("retry_seen", 1'b1, done);
  endtask

  task automatic test_reset();
    rd(srp_pkg::OFF_PARTITION_CFG, 1'b1, v);
    chk("cfg_reset", 32'h0000_1010, v);
    chk("cfg_reset", 32'h0000_1010, v);
    chk("ext_reset", 32'h0000_8010, rdata2);
    chk_bit("irq_reset", 1'b0, irq);
    $display("test reset done");
  endtask

  task automatic test_fields();
    wr(srp_pkg::OFF_PARTITION_CFG, 32'h0000_e3ec, 1'b1);
    seq_check(8'd12, 4);
    rd(srp_pkg::OFF_PARTITION_CFG, 1'b1, v);
    chk("cfg_masked", 32'h0000_030c, v);
    chk("cfg_masked", 32'h0000_030c, v);
    chk("ext_bank_ro", 32'h0000_e310, rdata2);
    wr(srp_pkg::OFF_PARTITION_CFG, 32'h0000_0505, 1'b0);
    rd(srp_pkg::OFF_PARTITION_CFG, 1'b0, v);
    chk("ns_cfg_read", 32'h0000_0000, v);
    rd(srp_pkg::OFF_PARTITION_CFG, 1'b1, v);
    chk("ns_cfg_write", 32'h0000_030c, v);
    // A bank count below the stage-2 banks would hand those banks to Secure use
    wr(srp_pkg::OFF_PARTITION_CFG, 32'h0000_0302, 1'b1);
    seq_check(8'd4, 8);
    rd(srp_pkg::OFF_PARTITION_CFG, 1'b1, v);
    chk("bank_clamp", 32'h0000_0304, v);
    wr(srp_pkg::OFF_PARTITION_CFG, 32'h0000_140c, 1'b1);
    seq_check(8'd4, 8);
    // Software only reuses the banks once the clearing walk is over
    rd(srp_pkg::OFF_CTRL_STATUS, 1'b1, v);
    chk("walk_idle", 32'h0000_0000, v);
    $display("test fields done");
  endtask

  task automatic test_id_views();
    rd(srp_pkg::OFF_ID_REG0, 1'b0, v);
    chk("ns_id0", 32'habcd_ef14, v);
    rd(srp_pkg::OFF_ID_REG1, 1'b0, v);
    chk("ns_id1", 32'h1234_560c, v);
    rd(srp_pkg::OFF_ID_REG0, 1'b1, v);
    chk("s_id0", 32'habcd_ef77, v);
    rd(8'h1c, 1'b1, v);
    chk("unmapped", 32'h0000_0000, v);
    $display("test id views done");
  endtask

  task automatic test_access();
    @(posedge clk_sys);
    acc_ns       <= 1'b1;
    acc_bank     <= 8'd11;
    acc_group    <= 8'd17;
    acc_group_en <= 1'b1;
    @(posedge clk_sys);
    acc_group_en <= 1'b0;
    #1;
    chk_bit("bank_ok_in", 1'b1, bank_ns_ok);
    chk_bit("group_fault", 1'b1, group_fault);
    @(posedge clk_sys);
    acc_bank     <= 8'd12;
    acc_group    <= 8'd15;
    acc_group_en <= 1'b1;
    @(posedge clk_sys);
    acc_group_en <= 1'b0;
    #1;
    chk_bit("bank_ok_out", 1'b0, bank_ns_ok);
    chk_bit("group_impl", 1'b0, group_fault);
    @(posedge clk_sys);
    attr_wr      <= 1'b1;
    attr_bank    <= 8'd5;
    bank_stalled <= 1'b1;
    @(posedge clk_sys);
    attr_wr      <= 1'b0;
    #1;
    chk_bit("attr_retry", 1'b1, retry_req);
    chk("attr_bank", 32'h0000_0005, {24'h0, retry_bank});
    $display("test access done");
  endtask

  task automatic test_irq();
    rd(srp_pkg::OFF_IRQ_STATUS, 1'b1, v);
    chk("status_all", 32'h0000_000f, v);
    chk_bit("irq_masked", 1'b0, irq);
    wr(srp_pkg::OFF_IRQ_ENABLE, 32'h0000_0004, 1'b1);
    #1;
    chk_bit("irq_enabled", 1'b1, irq);
    wr(srp_pkg::OFF_IRQ_CLEAR, 32'h0000_0004, 1'b1);
    #1;
    chk_bit("irq_cleared", 1'b0, irq);
    rd(srp_pkg::OFF_IRQ_STATUS, 1'b1, v);
    chk("status_left", 32'h0000_000b, v);
    $display("test irq done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs well under 400 cycles; a hang costs one mismatch
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end

  initial begin
    n_mismatch   = 0;
    n_tests      = 0;
    rst          = 1'b1;
    addr         = 8'h00;
    wdata        = 32'h0;
    wr_en        = 1'b0;
    rd_en        = 1'b0;
    secure       = 1'b0;
    id0_raw      = 32'habcd_ef77;
    id1_raw      = 32'h1234_5677;
    acc_bank     = 8'h00;
    acc_group    = 8'h00;
    acc_group_en = 1'b0;
    acc_ns       = 1'b0;
    attr_wr      = 1'b0;
    attr_bank    = 8'h00;
    bank_stalled = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_fields();
    test_id_views();
    test_access();
    test_irq();
    finish_test();
  end
endmodule
`default_nettype wire
